// *** design/serial_port.sv ***
// Purpose: serial port with synchronous shift mode 0 and 10-bit async
//          mode 1, registers on a classic wishbone slave
// Assumes: timer_ovf is a one-cycle pulse from the timer on core_clk
// Notes:   modes 2 and 3 hold the mode field but move no data
//
// Contract
// - buffer write goes to transmit, read returns receive
// - mode 0 data on data pin, clock on txd
// - mode 0 frame is 8 bits, LSB first
// - mode 0 rate 1/12 or 1/4 by option
// - mode 0 buffer write shifts out 8 bits
// - fast mode 0: lead 1, low 2 clocks
// - slow mode 0: lead 3, low 6 clocks
// - mode 0 transmit done after last bit
// - mode 0 receive needs enable and clear flag
// - mode 0 receive done after last rise, then halt
// - mode 1 frame: start, 8 bits LSB first, stop
// - mode 1 rate 1/16 or 1/32 of overflow
// - mode 1 bits start on divide-by-16 rollovers
// - mode 1 transmit done at tenth rollover
// - mode 1 watches receive pin at 16x rate
// - falling edge resets the divide-by-16 counter
// - bit is majority of states 7, 8, 9
// - nonzero start bit aborts reception
// - load buffer and stop bit under conditions
// - after mid stop bit, watch for edge again
`timescale 1ns/100ps
`include "serial_port_map.svh"
module serial_port (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// bit rate source
	input  wire logic        timer_ovf,
	// data pin, two-way
	input  wire logic        data_in,
	output logic             data_out,
	output logic             data_oe,
	// shift clock or transmit pin
	output logic             txd_out
);
	serial_port_pkg::port_state_t r_reg;
	serial_port_pkg::port_state_t r_next;

	localparam serial_port_pkg::port_state_t RESET_STATE = '{
		ack:      1'b0,
		rdata:    8'h00,
		mode:     `SP_MODE_SYNC,
		opt:      1'b0,
		ren:      1'b0,
		rb8:      1'b0,
		ti:       1'b0,
		ri:       1'b0,
		fast:     1'b0,
		rx_buf:   8'h00,
		m0_state: serial_port_pkg::M0_IDLE,
		m0_phase: 4'h0,
		m0_bit:   3'h0,
		m0_sh:    8'h00,
		m0_clk:   1'b1,
		m0_dout:  1'b1,
		m0_oe:    1'b0,
		tx16:     4'h0,
		tx_pend:  1'b0,
		tx_act:   1'b0,
		tx_sh:    10'h3ff,
		tx_idx:   4'h0,
		tx_line:  1'b1,
		txd:      1'b1,
		rx_state: serial_port_pkg::RX_IDLE,
		rx16:     4'h0,
		rx_prev:  1'b1,
		rx_smp:   2'h0,
		rx_idx:   4'h0,
		rx_sh:    8'h00
	};

	logic data_s;
	logic sample_tick;

	pin_sync #(
		.WIDTH(1)
	) u_data_sync (
		.core_clk     (core_clk),
		.rst          (rst),
		.pin_in       (data_in),
		.pin_sync_out (data_s)
	);

	baud_tick u_baud_tick (
		.core_clk    (core_clk),
		.rst         (rst),
		.timer_ovf   (timer_ovf),
		.fast        (r_reg.fast),
		.sample_tick (sample_tick)
	);

	always_comb begin
		logic [3:0] per;
		logic [3:0] pre;
		logic [3:0] low;
		logic [3:0] np;
		logic       wr;
		logic       buf_wr;
		logic       vote;
		logic       is_sync;
		logic       is_async;
		r_next   = r_reg;
		per      = r_reg.opt ? `SP_M0_PER_FAST : `SP_M0_PER_SLOW;
		pre      = r_reg.opt ? `SP_M0_PRE_FAST : `SP_M0_PRE_SLOW;
		low      = r_reg.opt ? `SP_M0_LOW_FAST : `SP_M0_LOW_SLOW;
		np       = 4'h0;
		buf_wr   = 1'b0;
		vote     = 1'b0;
		is_sync  = (r_reg.mode == `SP_MODE_SYNC);
		is_async = (r_reg.mode == `SP_MODE_ASYNC);
		wr       = wb_cyc_i & wb_stb_i & wb_we_i & r_reg.ack & wb_sel_i[0];

		// bus answer one cycle after the request, dropped the next
		r_next.ack = wb_cyc_i & wb_stb_i & ~r_reg.ack;
		if (r_next.ack) begin
			r_next.rdata = 8'h00;
			case (wb_adr_i)
				`SP_ADR_CONTROL: begin
					r_next.rdata[`SP_CTL_MODE_HI:`SP_CTL_MODE_LO] = r_reg.mode;
					r_next.rdata[`SP_CTL_OPT] = r_reg.opt;
					r_next.rdata[`SP_CTL_REN] = r_reg.ren;
					r_next.rdata[`SP_CTL_RB8] = r_reg.rb8;
					r_next.rdata[`SP_CTL_TI]  = r_reg.ti;
					r_next.rdata[`SP_CTL_RI]  = r_reg.ri;
				end
				`SP_ADR_BUFFER: begin
					r_next.rdata = r_reg.rx_buf;
				end
				`SP_ADR_STATUS: begin
					r_next.rdata[`SP_STS_TX_BUSY] = r_reg.tx_pend | r_reg.tx_act;
					r_next.rdata[`SP_STS_RX_BUSY] =
						(r_reg.rx_state == serial_port_pkg::RX_BUSY);
					r_next.rdata[`SP_STS_SYNC_BUSY] =
						(r_reg.m0_state != serial_port_pkg::M0_IDLE);
				end
				`SP_ADR_CONFIG: begin
					r_next.rdata[`SP_CFG_FAST] = r_reg.fast;
				end
				default: begin
					r_next.rdata = 8'h00;
				end
			endcase
		end

		// register writes take effect at the edge that drops the acknowledge, one cycle after it rises
		if (wr) begin
			case (wb_adr_i)
				`SP_ADR_CONTROL: begin
					r_next.mode = wb_dat_i[`SP_CTL_MODE_HI:`SP_CTL_MODE_LO];
					r_next.opt  = wb_dat_i[`SP_CTL_OPT];
					r_next.ren  = wb_dat_i[`SP_CTL_REN];
					r_next.rb8  = wb_dat_i[`SP_CTL_RB8];
					r_next.ti   = r_reg.ti & wb_dat_i[`SP_CTL_TI];
					r_next.ri   = r_reg.ri & wb_dat_i[`SP_CTL_RI];
				end
				`SP_ADR_BUFFER: begin
					buf_wr = 1'b1;
				end
				`SP_ADR_CONFIG: begin
					r_next.fast = wb_dat_i[`SP_CFG_FAST];
				end
				default: begin
				end
			endcase
		end

		// mode 0: shift engine, half duplex
		unique case (r_reg.m0_state)
			serial_port_pkg::M0_IDLE: begin
				r_next.m0_clk = 1'b1;
				r_next.m0_oe  = 1'b0;
				if (is_sync && buf_wr) begin
					r_next.m0_state = serial_port_pkg::M0_TX;
					r_next.m0_phase = 4'h0;
					r_next.m0_bit   = 3'h0;
					r_next.m0_sh    = wb_dat_i[7:0];
					r_next.m0_dout  = wb_dat_i[0];
					r_next.m0_oe    = 1'b1;
				end else if (is_sync && r_reg.ren && !r_reg.ri) begin
					r_next.m0_state = serial_port_pkg::M0_RX;
					r_next.m0_phase = 4'h0;
					r_next.m0_bit   = 3'h0;
				end
			end
			serial_port_pkg::M0_TX,
			serial_port_pkg::M0_RX: begin
				np = (r_reg.m0_phase == per - 4'h1) ? 4'h0
					: r_reg.m0_phase + 4'h1;
				r_next.m0_phase = np;
				// clock low from the lead count for the low count
				r_next.m0_clk = !(np >= pre && np < pre + low);
				if (r_reg.m0_state == serial_port_pkg::M0_RX
					&& np == pre + low) begin
					// partner data settled since the falling edge
					r_next.m0_sh = {data_s, r_reg.m0_sh[7:1]};
					if (r_reg.m0_bit == `SP_M0_LAST_BIT) begin
						r_next.rx_buf   = {data_s, r_reg.m0_sh[7:1]};
						r_next.ri       = 1'b1;
						r_next.m0_state = serial_port_pkg::M0_IDLE;
					end
				end
				if (np == 4'h0) begin
					if (r_reg.m0_bit == `SP_M0_LAST_BIT) begin
						r_next.m0_state = serial_port_pkg::M0_IDLE;
						r_next.m0_oe    = 1'b0;
						if (r_reg.m0_state == serial_port_pkg::M0_TX) begin
							r_next.ti = 1'b1;
						end
					end else begin
						r_next.m0_bit = r_reg.m0_bit + 3'h1;
						if (r_reg.m0_state == serial_port_pkg::M0_TX) begin
							r_next.m0_sh   = {1'b1, r_reg.m0_sh[7:1]};
							r_next.m0_dout = r_reg.m0_sh[1];
						end
					end
				end
			end
			default: begin
				r_next.m0_state = serial_port_pkg::M0_IDLE;
			end
		endcase

		// mode 1 transmitter on the free-running divide-by-16 counter
		if (sample_tick) begin
			r_next.tx16 = r_reg.tx16 + 4'h1;
		end
		if (is_async && buf_wr && !r_reg.tx_pend && !r_reg.tx_act) begin
			r_next.tx_sh   = {1'b1, wb_dat_i[7:0], 1'b0};
			r_next.tx_pend = 1'b1;
		end
		if (sample_tick && r_reg.tx16 == `SP_DIV_LAST) begin
			if (r_reg.tx_pend) begin
				r_next.tx_pend = 1'b0;
				r_next.tx_act  = 1'b1;
				r_next.tx_line = r_reg.tx_sh[0];
				r_next.tx_sh   = {1'b1, r_reg.tx_sh[9:1]};
				r_next.tx_idx  = 4'h1;
			end else if (r_reg.tx_act) begin
				r_next.tx_line = r_reg.tx_sh[0];
				r_next.tx_sh   = {1'b1, r_reg.tx_sh[9:1]};
				r_next.tx_idx  = r_reg.tx_idx + 4'h1;
				if (r_reg.tx_idx == `SP_IDX_STOP) begin
					r_next.tx_act = 1'b0;
					r_next.ti     = 1'b1;
				end
			end
		end

		// mode 1 receiver, sampled on the 16x tick
		if (!is_async || !r_reg.ren) begin
			r_next.rx_state = serial_port_pkg::RX_IDLE;
			r_next.rx_prev  = 1'b1;
		end else if (sample_tick) begin
			r_next.rx_prev = data_s;
			unique case (r_reg.rx_state)
				serial_port_pkg::RX_IDLE: begin
					if (r_reg.rx_prev && !data_s) begin
						r_next.rx_state = serial_port_pkg::RX_BUSY;
						r_next.rx16     = 4'h0;
						r_next.rx_idx   = `SP_IDX_START;
					end
				end
				serial_port_pkg::RX_BUSY: begin
					r_next.rx16 = r_reg.rx16 + 4'h1;
					if (r_reg.rx16 == `SP_SMP_FIRST) begin
						r_next.rx_smp[0] = data_s;
					end
					if (r_reg.rx16 == `SP_SMP_SECOND) begin
						r_next.rx_smp[1] = data_s;
					end
					if (r_reg.rx16 == `SP_SMP_THIRD) begin
						vote = (r_reg.rx_smp[0] & r_reg.rx_smp[1])
							| (r_reg.rx_smp[0] & data_s)
							| (r_reg.rx_smp[1] & data_s);
						r_next.rx_idx = r_reg.rx_idx + 4'h1;
						if (r_reg.rx_idx == `SP_IDX_START) begin
							if (vote) begin
								r_next.rx_state = serial_port_pkg::RX_IDLE;
							end
						end else if (r_reg.rx_idx == `SP_IDX_STOP) begin
							if (!r_reg.ri && (!r_reg.opt || vote)) begin
								r_next.rx_buf = r_reg.rx_sh;
								r_next.rb8    = vote;
								r_next.ri     = 1'b1;
							end
							r_next.rx_state = serial_port_pkg::RX_IDLE;
						end else begin
							r_next.rx_sh = {vote, r_reg.rx_sh[7:1]};
						end
					end
				end
			endcase
		end

		r_next.txd = (r_next.mode == `SP_MODE_SYNC) ? r_next.m0_clk
			: r_next.tx_line;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_reg <= RESET_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_ack_o = r_reg.ack;
	assign wb_dat_o = {24'h000000, r_reg.rdata};
	assign data_out = r_reg.m0_dout;
	assign data_oe  = r_reg.m0_oe;
	assign txd_out  = r_reg.txd;
endmodule

// *** design/serial_port_map.svh ***
// Purpose: register offsets, field positions and timing counts of the
//          serial port
// Assumes: wishbone byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// register byte offsets
`define SP_ADR_CONTROL   4'h0
`define SP_ADR_BUFFER    4'h4
`define SP_ADR_STATUS    4'h8
`define SP_ADR_CONFIG    4'hc

// serial_control_register fields
`define SP_CTL_MODE_HI   7
`define SP_CTL_MODE_LO   6
`define SP_CTL_OPT       5
`define SP_CTL_REN       4
`define SP_CTL_RB8       2
`define SP_CTL_TI        1
`define SP_CTL_RI        0

// status and config fields
`define SP_STS_TX_BUSY   0
`define SP_STS_RX_BUSY   1
`define SP_STS_SYNC_BUSY 2
`define SP_CFG_FAST      0

// mode field values
`define SP_MODE_SYNC     2'h0
`define SP_MODE_ASYNC    2'h1

// mode 0 bit timing in core clocks: period, lead, low time
`define SP_M0_PER_SLOW   4'hc
`define SP_M0_PRE_SLOW   4'h3
`define SP_M0_LOW_SLOW   4'h6
`define SP_M0_PER_FAST   4'h4
`define SP_M0_PRE_FAST   4'h1
`define SP_M0_LOW_FAST   4'h2
`define SP_M0_LAST_BIT   3'h7

// mode 1 divide-by-16 counter and frame positions
`define SP_DIV_LAST      4'hf
`define SP_SMP_FIRST     4'h7
`define SP_SMP_SECOND    4'h8
`define SP_SMP_THIRD     4'h9
`define SP_IDX_START     4'h0
`define SP_IDX_STOP      4'h9

`endif

// *** design/serial_port_pkg.sv ***
// Purpose: types shared by the serial port modules
// Assumes: nothing
// Notes:   state of each module is one packed struct
package serial_port_pkg;

	typedef enum logic [1:0] {
		M0_IDLE = 2'b00,
		M0_TX   = 2'b01,
		M0_RX   = 2'b10
	} sync_state_t;

	typedef enum logic {
		RX_IDLE = 1'b0,
		RX_BUSY = 1'b1
	} async_rx_state_t;

	typedef struct packed {
		logic            ack;
		logic [7:0]      rdata;
		logic [1:0]      mode;
		logic            opt;
		logic            ren;
		logic            rb8;
		logic            ti;
		logic            ri;
		logic            fast;
		logic [7:0]      rx_buf;
		sync_state_t     m0_state;
		logic [3:0]      m0_phase;
		logic [2:0]      m0_bit;
		logic [7:0]      m0_sh;
		logic            m0_clk;
		logic            m0_dout;
		logic            m0_oe;
		logic [3:0]      tx16;
		logic            tx_pend;
		logic            tx_act;
		logic [9:0]      tx_sh;
		logic [3:0]      tx_idx;
		logic            tx_line;
		logic            txd;
		async_rx_state_t rx_state;
		logic [3:0]      rx16;
		logic            rx_prev;
		logic [1:0]      rx_smp;
		logic [3:0]      rx_idx;
		logic [7:0]      rx_sh;
	} port_state_t;

	typedef struct packed {
		logic div;
		logic tick;
	} tick_state_t;

endpackage

// *** design/pin_sync.sv ***
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: input is asynchronous to core_clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// pin side
	input  wire logic [WIDTH-1:0] pin_in,
	// core side
	output logic      [WIDTH-1:0] pin_sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t r_reg;
	sync_t r_next;

	always_comb begin
		r_next    = r_reg;
		r_next.s1 = pin_in;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_reg <= '1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pin_sync_out = r_reg.s2;
endmodule

// *** design/baud_tick.sv ***
// Purpose: sample tick at sixteen times the mode 1 bit rate
// Assumes: timer overflow is a one-cycle pulse on core_clk
// Notes:   fast passes every overflow, otherwise every second one
`timescale 1ns/100ps
module baud_tick (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// rate source
	input  wire logic timer_ovf,
	input  wire logic fast,
	// sample tick
	output logic      sample_tick
);
	serial_port_pkg::tick_state_t r_reg;
	serial_port_pkg::tick_state_t r_next;

	always_comb begin
		r_next = r_reg;
		if (timer_ovf) begin
			r_next.div = ~r_reg.div;
		end
		r_next.tick = timer_ovf & (fast | r_reg.div);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sample_tick = r_reg.tick;
endmodule

// *** test/serial_partner.sv ***
// Purpose: external shift device and async line driver on the data pin
// Assumes: the data pin has a pull-up; the port's drive wins
// Notes:   tasks are called by the bench
`timescale 1ns/100ps
module serial_partner (
	// clock
	input  wire logic core_clk,
	// port pins
	input  wire logic txd_out,
	input  wire logic data_out,
	input  wire logic data_oe,
	output logic      data_in
);
	logic       drv_en  = 1'b0;
	logic       drv_val = 1'b1;
	logic       m0_en   = 1'b0;
	logic [7:0] m0_byte = 8'h00;
	logic [7:0] m0_cap  = 8'h00;
	int         m0_idx  = 0;
	// released line floats up to the pull-up level
	assign data_in = data_oe ? data_out : (drv_en ? drv_val : 1'b1);
	always @(negedge txd_out) begin
		if (m0_en && m0_idx < 8) begin
			drv_en  <= 1'b1;
			drv_val <= m0_byte[m0_idx];
			m0_idx  <= m0_idx + 1;
		end
	end
	always @(posedge txd_out) begin
		if (data_oe)
			m0_cap <= {data_in, m0_cap[7:1]};
	end
	task automatic m0_load(input logic [7:0] b);
		m0_byte = b;
		m0_idx  = 0;
		m0_en   = 1'b1;
	endtask
	task automatic release_pin();
		m0_en  <= 1'b0;
		drv_en <= 1'b0;
	endtask
	// n bits of f, lsb first, each held bt cycles
	task automatic send(input logic [9:0] f, input int n, input int bt);
		drv_en <= 1'b1;
		for (int i = 0; i < n; i++) begin
			drv_val <= f[i];
			repeat (bt) @(posedge core_clk);
		end
		drv_val <= 1'b1;
	endtask
endmodule

// *** test/serial_port_chk.sv ***
// Purpose: concurrent checks on the serial port pins and bus
// Assumes: mode and option mirrored from bus writes
// Notes:   bound to serial_port
`timescale 1ns/100ps
`include "serial_port_map.svh"
module serial_port_chk (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// pins
	input wire logic        data_out,
	input wire logic        data_oe,
	input wire logic        txd_out
);
	logic [1:0] mode_reg;
	logic       opt_reg;
	logic [7:0] len_reg;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= 2'h0;
			opt_reg  <= 1'b0;
			len_reg  <= 8'h00;
		end else begin
			if (wb_ack_o && wb_we_i && wb_sel_i[0]
			    && wb_adr_i == `SP_ADR_CONTROL) begin
				mode_reg <= wb_dat_i[7:6];
				opt_reg  <= wb_dat_i[5];
			end
			len_reg <= data_oe ? len_reg + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_low_fast;
		!txd_out [*2] ##1 txd_out;
	endsequence
	sequence s_low_slow;
		!txd_out [*6] ##1 txd_out;
	endsequence
	chk_ack_once: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse one cycle after request");
	chk_read_pad: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read data not zero");
	chk_unmapped_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_fast_low: assert property (
		mode_reg == 2'h0 && opt_reg && $fell(txd_out) |-> s_low_fast)
		else $error("fast shift clock low time wrong");
	chk_slow_low: assert property (
		mode_reg == 2'h0 && !opt_reg && $fell(txd_out) |-> s_low_slow)
		else $error("slow shift clock low time wrong");
	chk_lead_fast: assert property (
		data_oe && opt_reg && $fell(txd_out) |-> $stable(data_out))
		else $error("data not set one cycle before clock fall");
	chk_lead_slow: assert property (
		data_oe && !opt_reg && $fell(txd_out) |-> data_out == $past(data_out, 3))
		else $error("data not set three cycles before clock fall");
	chk_frame_len: assert property (
		$fell(data_oe) |-> len_reg == (opt_reg ? 8'h20 : 8'h60))
		else $error("shift frame length wrong");
	chk_oe_mode: assert property (
		data_oe |-> mode_reg == `SP_MODE_SYNC)
		else $error("data pin driven outside mode 0");
endmodule
bind serial_port serial_port_chk i_serial_port_chk (
	.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .data_out, .data_oe, .txd_out
);

// *** test/serial_port_tb.sv ***
// Purpose: self-checking bench for the serial port
// Assumes: overflow every second clock, so a fast bit is 32 clocks
// Notes:   registers reached through wishbone tasks
`timescale 1ns/100ps
`include "serial_port_map.svh"
module serial_port_tb;
	logic        core_clk  = 1'b0;
	logic        rst       = 1'b1;
	logic        wb_cyc_i  = 1'b0;
	logic        wb_stb_i  = 1'b0;
	logic        wb_we_i   = 1'b0;
	logic [3:0]  wb_adr_i  = 4'h0;
	logic [3:0]  wb_sel_i  = 4'h0;
	logic [31:0] wb_dat_i  = 32'h0;
	logic        timer_ovf = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, data_in, data_out, data_oe, txd_out;
	logic [9:0]  fr;
	logic        hi;
	int          fails     = 0;
	int          tests_run = 0;
	serial_port i_serial_port (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.timer_ovf, .data_in, .data_out, .data_oe, .txd_out);
	serial_partner i_serial_partner (.core_clk, .txd_out, .data_out,
		.data_oe, .data_in);
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) timer_ovf <= ~timer_ovf;
	task automatic end_sim();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic we,
	                   input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			fails++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	// poll control until bit b is set
	task automatic wait_flag(input int b);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			bus(`SP_ADR_CONTROL, 1'b0, 8'h00, q);
			n++;
		end while (q[b] !== 1'b1 && n < 400);
	endtask
	// sample an async frame mid-bit on the transmit line
	task automatic cap(input int bt, output logic [9:0] f);
		int n;
		n = 0;
		while (txd_out !== 1'b0 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		repeat (bt / 2) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			f[i] = txd_out;
			repeat (bt) @(posedge core_clk);
		end
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		fails++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(`SP_ADR_CONTROL, 8'h00);
		rd(4'h2, 8'h00);
		wr(`SP_ADR_STATUS, 8'hff);
		rd(`SP_ADR_STATUS, 8'h00);
		for (int k = 0; k < 2; k++) begin
			wr(`SP_ADR_CONTROL, k ? 8'h20 : 8'h00);
			wr(`SP_ADR_BUFFER, k ? 8'h3a : 8'hc5);
			wait_flag(1);
			chk({24'h0, i_serial_partner.m0_cap},
				k ? 32'h3a : 32'hc5);
			rd(`SP_ADR_CONTROL, k ? 8'h22 : 8'h02);
		end
		rd(`SP_ADR_BUFFER, 8'h00);
		wr(`SP_ADR_CONTROL, 8'h22);
		rd(`SP_ADR_CONTROL, 8'h22);
		wr(`SP_ADR_CONTROL, 8'h00);
		rd(`SP_ADR_CONTROL, 8'h00);
		i_serial_partner.m0_load(8'h6b);
		wr(`SP_ADR_CONTROL, 8'h10);
		wait_flag(0);
		rd(`SP_ADR_BUFFER, 8'h6b);
		hi = 1'b1;
		repeat (100) begin
			@(posedge core_clk);
			if (txd_out !== 1'b1)
				hi = 1'b0;
		end
		chk({31'h0, hi}, 32'h1);
		i_serial_partner.release_pin();
		for (int k = 0; k < 2; k++) begin
			wr(`SP_ADR_CONFIG, k ? 8'h01 : 8'h00);
			rd(`SP_ADR_CONFIG, k ? 8'h01 : 8'h00);
			wr(`SP_ADR_CONTROL, 8'h40);
			wr(`SP_ADR_BUFFER, k ? 8'h3a : 8'hc5);
			rd(`SP_ADR_STATUS, 8'h01);
			cap(k ? 32 : 64, fr);
			chk({22'h0, fr},
				{22'h0, 1'b1, k ? 8'h3a : 8'hc5, 1'b0});
			rd(`SP_ADR_CONTROL, 8'h42);
		end
		wr(`SP_ADR_CONTROL, 8'h50);
		i_serial_partner.send(10'h000, 1, 6);
		repeat (200) @(posedge core_clk);
		rd(`SP_ADR_CONTROL, 8'h50);
		i_serial_partner.send({1'b1, 8'ha7, 1'b0}, 10, 32);
		rd(`SP_ADR_BUFFER, 8'ha7);
		rd(`SP_ADR_CONTROL, 8'h55);
		i_serial_partner.send({1'b1, 8'h11, 1'b0}, 10, 32);
		rd(`SP_ADR_BUFFER, 8'ha7);
		wr(`SP_ADR_CONTROL, 8'h70);
		i_serial_partner.send({1'b0, 8'h22, 1'b0}, 10, 32);
		repeat (40) @(posedge core_clk);
		rd(`SP_ADR_CONTROL, 8'h70);
		i_serial_partner.send({1'b1, 8'h3c, 1'b0}, 10, 32);
		rd(`SP_ADR_BUFFER, 8'h3c);
		rd(`SP_ADR_CONTROL, 8'h75);
		end_sim();
	end
endmodule
